// *** pkg/flash_ctl_pkg.sv ***
// Opcodes, field positions, reset values, timing constants and carriers for the flash controller.
// Assumes a 25 MHz system clock and a host that drives the serial clock and chip select.
package flash_ctl_pkg;
	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_WR_SET = 8'h06;
	localparam logic [7:0] OP_WR_CLR = 8'h04;
	localparam logic [7:0] OP_ST_RD = 8'h05;
	localparam logic [7:0] OP_ST_WR = 8'h01;
	localparam logic [7:0] OP_FR_RD = 8'h48;
	localparam logic [7:0] OP_FR_WR = 8'h42;
	localparam logic [7:0] OP_ERASE_ALL_A = 8'hC7;
	localparam logic [7:0] OP_ERASE_ALL_B = 8'h60;
	localparam logic [7:0] OP_ERASE_SEC_A = 8'hD7;
	localparam logic [7:0] OP_ERASE_SEC_B = 8'h20;
	localparam logic [7:0] OP_ERASE_B32 = 8'h52;
	localparam logic [7:0] OP_ERASE_B64 = 8'hD8;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_PROG_Q_A = 8'h32;
	localparam logic [7:0] OP_PROG_Q_B = 8'h38;
	localparam logic [7:0] OP_INFO_PROG = 8'h62;
	localparam logic [7:0] OP_NIB_ON = 8'h35;
	localparam logic [7:0] OP_NIB_OFF = 8'hF5;
	localparam logic [7:0] OP_SUSP_A = 8'h75;
	localparam logic [7:0] OP_SUSP_B = 8'hB0;
	localparam logic [7:0] OP_RES_A = 8'h7A;
	localparam logic [7:0] OP_RES_B = 8'h30;
	localparam logic [7:0] OP_RST_ARM = 8'h66;
	localparam logic [7:0] OP_RST_GO = 8'h99;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int ST_BUSY = 0;
	localparam int ST_WPL = 1;
	localparam int ST_PROT_LO = 2;
	localparam int ST_QALLOW = 6;
	localparam int ST_SWLOCK = 7;
	localparam int FR_AREA = 1;
	localparam int FR_PROGRAM_PAUSED_FLAG = 2;
	localparam int FR_ERASE_PAUSED_FLAG = 3;
	localparam int FR_LOCK_LO = 4;
	localparam logic [5:0] ST_NV_RESET = 6'h00;
	localparam logic [4:0] FR_OTP_RESET = 5'h00;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int SUSP_LAT_US = 100;
	localparam int SUSP_LAT_CYC = SUSP_LAT_US * CLK_MHZ;
	localparam int STWR_CYC = 64;
	localparam int FRWR_CYC = 64;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_PGM = 3'h1,
		OP_ERS = 3'h2,
		OP_CHIP = 3'h3,
		OP_CFG = 3'h4
	} op_kind_type;
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] data;
		logic has_data;
	} frame_type;
	typedef struct packed {
		logic busy;
		logic [2:0] kind;
		logic prog_go;
		logic erase_go;
		logic chip_go;
	} core_type;
endpackage

// *** rtl/flash_write_erase_suspend_control.sv ***
// Command decoder for write control, erase, status/function register, nibble mode and suspend.
// Assumes the host owns the serial clock and chip select; the array core reports completion.
// ----------------------------------------
// Summary of operation
// RULE1 - Chip erase opcodes with latch set start whole-array erase to ones.
// RULE2 - Erase starts only if chip select rises right after opcode; else dropped. Code starts it on any byte boundary after the opcode.
// RULE3 - Write-permit set opcode sets the write permit latch.
// RULE4 - Latch is clear after power-up.
// RULE5 - All program, erase and register writes need the latch set first.
// RULE6 - Latch clears automatically when a write, program or erase finishes.
// RULE7 - Write-permit clear opcode clears the latch.
// RULE8 - Status read returns busy flag and stays accepted while busy.
// RULE9 - Status write sets protect range, write lock and quad allow bits.
// RULE10 - Function register read shifts out the function register.
// RULE11 - Function register write can move protected area to bottom.
// RULE12 - Info-row lock bits and area select are one-time programmable.
// RULE13 - Nibble entry makes all later commands four bits wide until exit or power.
// RULE14 - Nibble exit returns to serial mode; host sends it as two clocks.
// RULE15 - Both suspend and resume opcodes work in either mode for sector, block, program.
// RULE16 - Suspend sets program-paused bit2 or erase-paused bit3.
// RULE17 - Ready within 100us of suspend; host waits 400us before next suspend.
// RULE18 - Suspend clears latch; only reads, resume and reset accepted meanwhile.
// RULE19 - After suspend, commands refused until ready; host polls busy flag.
// RULE20 - Resume restarts the operation and clears the matching paused flag.
// RULE21 - Busy time before suspend and after resume totals the uninterrupted time.
// RULE22 - Listed read, identification, parameter and no-op commands run while suspended.
// RULE23 - Soft reset works only directly after the arm opcode, also during suspend.
// RULE24 - Busy flag reads one during internal operation, zero when done.
// RULE25 - Commands outside the suspend set are ignored while suspended.
// ----------------------------------------
`timescale 1ns/1ps
module flash_write_erase_suspend_control #(
	parameter int SUSP_LAT = flash_ctl_pkg::SUSP_LAT_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o,
	input wire logic core_done_i,
	output logic prog_start_o,
	output logic erase_start_o,
	output logic chip_erase_start_o,
	output logic core_pause_o,
	output logic core_resume_o,
	output logic soft_reset_o,
	output logic nibble_mode_o,
	output logic [7:0] status_o,
	output logic [7:0] func_o
);
	// ----------------------------------------
	// Link side: shift in on sclk rising, out on falling
	// ----------------------------------------
	logic [7:0] sh_in;
	logic [3:0] bitcnt;
	logic [7:0] op_l;
	logic [7:0] dat_l;
	logic got_op;
	logic got_dat;
	logic nib_l;
	logic [7:0] out_sh;
	logic [7:0] rd_src_l;
	logic frame_tgl;
	logic [7:0] status_l;
	logic [7:0] func_l;
	logic [7:0] st_s1;
	logic [7:0] st_s2;
	logic [7:0] fr_s1;
	logic [7:0] fr_s2;
	logic nib_s1;
	logic nib_s2;
	logic [3:0] step;
	logic [7:0] nxt_in;
	assign step = nib_l ? 4'h4 : 4'h1;
	assign nxt_in = nib_l ? {sh_in[3:0], io_i} : {sh_in[6:0], io_i[0]};
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			sh_in <= 8'h00;
			bitcnt <= 4'h0;
			got_op <= 1'b0;
			got_dat <= 1'b0;
		end else begin
			sh_in <= nxt_in;
			if (bitcnt + step == 4'h8) begin
				bitcnt <= 4'h0;
				if (!got_op) begin
					op_l <= nxt_in;
					got_op <= 1'b1;
				end else if (!got_dat) begin
					dat_l <= nxt_in;
					got_dat <= 1'b1;
				end
			end else begin
				bitcnt <= bitcnt + step;
			end
		end
	end
	always_ff @(posedge sclk_i) begin
		st_s1 <= status_o;
		st_s2 <= st_s1;
		fr_s1 <= func_o;
		fr_s2 <= fr_s1;
	end
	// The serial clock stops between frames, so the width is staged on the system clock.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nib_s1 <= 1'b0;
			nib_s2 <= 1'b0;
		end else begin
			nib_s1 <= nibble_mode_o;
			nib_s2 <= nib_s1;
		end
	end
	// The frame width is fixed when chip select falls.
	always_ff @(negedge cs_n_i) begin
		nib_l <= nib_s2; // RULE13
	end
	// Read source chosen once the opcode is in; status stays readable while busy.
	assign rd_src_l = (op_l == flash_ctl_pkg::OP_FR_RD) ? fr_s2 : st_s2; // RULE8 RULE10
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			out_sh <= 8'h00;
		end else if (got_op && bitcnt == 4'h0 && (op_l == flash_ctl_pkg::OP_ST_RD
				|| op_l == flash_ctl_pkg::OP_FR_RD)) begin
			out_sh <= rd_src_l;
		end else begin
			out_sh <= nib_l ? {out_sh[3:0], 4'h0} : {out_sh[6:0], 1'b0};
		end
	end
	logic rd_on;
	assign rd_on = got_op && !cs_n_i && (op_l == flash_ctl_pkg::OP_ST_RD
		|| op_l == flash_ctl_pkg::OP_FR_RD);
	assign io_o = nib_l ? out_sh[7:4] : {2'b00, out_sh[7], 1'b0};
	assign io_oe_o = !rd_on ? 4'h0 : (nib_l ? 4'hF : 4'h2); // RULE13
	// Chip select rising ends a frame; its count of bits decides validity.
	logic frame_ok;
	assign frame_ok = got_op && bitcnt == 4'h0;
	flash_ctl_pkg::frame_type fr_hold;
	always_ff @(posedge cs_n_i) begin
		fr_hold <= '{opcode: op_l, data: dat_l, has_data: got_dat};
	end
	logic ok_hold;
	always_ff @(posedge cs_n_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_tgl <= 1'b0;
			ok_hold <= 1'b0;
		end else begin
			frame_tgl <= ~frame_tgl;
			ok_hold <= frame_ok;
		end
	end
	// ----------------------------------------
	// System side: synchronise frame event
	// ----------------------------------------
	logic tg1;
	logic tg2;
	logic tg3;
	logic fr_ev;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tg1 <= 1'b0;
			tg2 <= 1'b0;
			tg3 <= 1'b0;
		end else begin
			tg1 <= frame_tgl;
			tg2 <= tg1;
			tg3 <= tg2;
		end
	end
	assign fr_ev = (tg2 ^ tg3) && ok_hold;
	logic [7:0] op;
	logic [7:0] dat;
	assign op = fr_hold.opcode;
	assign dat = fr_hold.data;
	// ----------------------------------------
	// Command classes
	// ----------------------------------------
	logic latch;
	logic busy;
	logic paused;
	logic settle;
	logic rst_armed;
	flash_ctl_pkg::op_kind_type kind;
	flash_ctl_pkg::op_kind_type paused_kind;
	logic [3:0] protect_range_bits;
	logic status_write_lock_bit;
	logic quad_allow_bit;
	logic protect_area_select_bit;
	logic [3:0] info_row_lock_bits;
	logic program_paused_flag;
	logic erase_paused_flag;
	logic is_erase_sb;
	logic is_chip;
	logic is_prog;
	logic is_susp;
	logic is_res;
	logic susp_ok;
	logic accept;
	assign is_erase_sb = op == flash_ctl_pkg::OP_ERASE_SEC_A || op == flash_ctl_pkg::OP_ERASE_SEC_B
		|| op == flash_ctl_pkg::OP_ERASE_B32 || op == flash_ctl_pkg::OP_ERASE_B64;
	assign is_chip = op == flash_ctl_pkg::OP_ERASE_ALL_A || op == flash_ctl_pkg::OP_ERASE_ALL_B;
	assign is_prog = op == flash_ctl_pkg::OP_PROG || op == flash_ctl_pkg::OP_PROG_Q_A
		|| op == flash_ctl_pkg::OP_PROG_Q_B || op == flash_ctl_pkg::OP_INFO_PROG;
	assign is_susp = op == flash_ctl_pkg::OP_SUSP_A || op == flash_ctl_pkg::OP_SUSP_B; // RULE15
	assign is_res = op == flash_ctl_pkg::OP_RES_A || op == flash_ctl_pkg::OP_RES_B; // RULE15
	// Commands that run while an operation is paused.
	always_comb begin
		case (op)
			8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED,
			8'h05, 8'h48, 8'h7A, 8'h30, 8'hAB, 8'hC0, 8'h9F, 8'h90, 8'hAF,
			8'h4B, 8'h5A, 8'h00, 8'h66, 8'h99, 8'h68: susp_ok = 1'b1; // RULE22
			default: susp_ok = 1'b0;
		endcase
	end
	assign accept = fr_ev && !settle && (!paused || susp_ok); // RULE18 RULE19 RULE25
	// Only sector erase, block erase and program may be paused.
	logic can_pause;
	assign can_pause = kind == flash_ctl_pkg::OP_PGM || kind == flash_ctl_pkg::OP_ERS; // RULE15
	// ----------------------------------------
	// Operation state
	// ----------------------------------------
	logic [$clog2(SUSP_LAT + 1)-1:0] settle_cnt;
	logic [6:0] cfg_cnt;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy <= 1'b0;
			kind <= flash_ctl_pkg::OP_NONE;
			paused <= 1'b0;
			paused_kind <= flash_ctl_pkg::OP_NONE;
			settle <= 1'b0;
			settle_cnt <= '0;
			cfg_cnt <= 7'h00;
		end else begin
			if (settle) begin
				if (settle_cnt == '0)
					settle <= 1'b0; // RULE17
				else
					settle_cnt <= settle_cnt - 1'b1;
			end
			if (busy && kind == flash_ctl_pkg::OP_CFG) begin
				if (cfg_cnt == 7'h00) begin
					busy <= 1'b0;
					kind <= flash_ctl_pkg::OP_NONE;
				end else begin
					cfg_cnt <= cfg_cnt - 7'h01;
				end
			end else if (busy && core_done_i) begin
				busy <= 1'b0; // RULE24
				kind <= flash_ctl_pkg::OP_NONE;
			end
			if (accept && busy && is_susp && can_pause) begin
				busy <= 1'b0;
				paused <= 1'b1;
				paused_kind <= kind;
				kind <= flash_ctl_pkg::OP_NONE;
				settle <= 1'b1;
				settle_cnt <= SUSP_LAT[$bits(settle_cnt)-1:0];
			end else if (accept && paused && is_res) begin
				paused <= 1'b0; // RULE20 RULE21
				busy <= 1'b1;
				kind <= paused_kind;
			end else if (accept && !busy && !paused && latch) begin
				if (is_chip) begin
					busy <= 1'b1; // RULE1 RULE2
					kind <= flash_ctl_pkg::OP_CHIP;
				end else if (is_erase_sb) begin
					busy <= 1'b1; // RULE2 RULE5
					kind <= flash_ctl_pkg::OP_ERS;
				end else if (is_prog) begin
					busy <= 1'b1; // RULE5
					kind <= flash_ctl_pkg::OP_PGM;
				end else if ((op == flash_ctl_pkg::OP_ST_WR || op == flash_ctl_pkg::OP_FR_WR)
						&& fr_hold.has_data) begin
					busy <= 1'b1;
					kind <= flash_ctl_pkg::OP_CFG;
					cfg_cnt <= (op == flash_ctl_pkg::OP_ST_WR) ? 7'(flash_ctl_pkg::STWR_CYC)
						: 7'(flash_ctl_pkg::FRWR_CYC);
				end
			end
		end
	end
	logic starting;
	assign starting = accept && !busy && !paused && latch;
	// Write permit latch; completion and suspend clear it.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			latch <= 1'b0; // RULE4
		end else if (busy && (core_done_i || (kind == flash_ctl_pkg::OP_CFG && cfg_cnt == 7'h00))) begin
			latch <= 1'b0; // RULE6
		end else if (accept && busy && is_susp && can_pause) begin
			latch <= 1'b0; // RULE18
		end else if (accept && !busy && op == flash_ctl_pkg::OP_WR_SET && !paused) begin
			latch <= 1'b1; // RULE3
		end else if (accept && !busy && op == flash_ctl_pkg::OP_WR_CLR) begin
			latch <= 1'b0; // RULE7
		end
	end
	// Non-volatile status bits and one-time function bits.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{status_write_lock_bit, quad_allow_bit, protect_range_bits} <= flash_ctl_pkg::ST_NV_RESET;
			{info_row_lock_bits, protect_area_select_bit} <= flash_ctl_pkg::FR_OTP_RESET;
		end else if (starting && fr_hold.has_data) begin
			if (op == flash_ctl_pkg::OP_ST_WR) begin
				protect_range_bits <= dat[5:2]; // RULE9
				quad_allow_bit <= dat[flash_ctl_pkg::ST_QALLOW];
				status_write_lock_bit <= dat[flash_ctl_pkg::ST_SWLOCK];
			end else if (op == flash_ctl_pkg::OP_FR_WR) begin
				protect_area_select_bit <= protect_area_select_bit | dat[flash_ctl_pkg::FR_AREA]; // RULE11 RULE12
				info_row_lock_bits <= info_row_lock_bits | dat[7:4]; // RULE12
			end
		end
	end
	// Paused flags follow the paused operation kind.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			program_paused_flag <= 1'b0;
			erase_paused_flag <= 1'b0;
		end else if (accept && busy && is_susp) begin
			program_paused_flag <= kind == flash_ctl_pkg::OP_PGM; // RULE16
			erase_paused_flag <= kind == flash_ctl_pkg::OP_ERS; // RULE16
		end else if (accept && paused && is_res) begin
			program_paused_flag <= 1'b0; // RULE20
			erase_paused_flag <= 1'b0;
		end
	end
	// Nibble mode and soft reset arming.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nibble_mode_o <= 1'b0;
			rst_armed <= 1'b0;
			soft_reset_o <= 1'b0;
		end else begin
			soft_reset_o <= 1'b0;
			if (accept) begin
				rst_armed <= op == flash_ctl_pkg::OP_RST_ARM;
				if (op == flash_ctl_pkg::OP_RST_GO && rst_armed)
					soft_reset_o <= 1'b1; // RULE23
				if (op == flash_ctl_pkg::OP_NIB_ON && !busy)
					nibble_mode_o <= 1'b1; // RULE13
				if (op == flash_ctl_pkg::OP_NIB_OFF && nibble_mode_o && !busy)
					nibble_mode_o <= 1'b0; // RULE14
			end
		end
	end
	// Start, pause and resume strobes to the array core.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_start_o <= 1'b0;
			erase_start_o <= 1'b0;
			chip_erase_start_o <= 1'b0;
			core_pause_o <= 1'b0;
			core_resume_o <= 1'b0;
		end else begin
			prog_start_o <= starting && is_prog;
			erase_start_o <= starting && is_erase_sb;
			chip_erase_start_o <= starting && is_chip; // RULE1
			core_pause_o <= accept && busy && is_susp && can_pause;
			core_resume_o <= accept && paused && is_res; // RULE21
		end
	end
	// ----------------------------------------
	// Status and function register views
	// ----------------------------------------
	assign status_o = {status_write_lock_bit, quad_allow_bit, protect_range_bits, latch,
		busy | settle}; // RULE24 RULE19
	assign func_o = {info_row_lock_bits, erase_paused_flag, program_paused_flag,
		protect_area_select_bit, 1'b0};
endmodule

// *** bench/flash_ctl_properties.sv ***
// Port-level checks for the write, erase and suspend controller.
// Assumes it is bound into flash_write_erase_suspend_control.
`timescale 1ns/1ps
module flash_ctl_checker (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_i,
	input wire logic core_done_i,
	input wire logic prog_start_o,
	input wire logic erase_start_o,
	input wire logic chip_erase_start_o,
	input wire logic core_pause_o,
	input wire logic core_resume_o,
	input wire logic nibble_mode_o,
	input wire logic [7:0] status_o,
	input wire logic [7:0] func_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic paused;
	assign paused = func_o[2] | func_o[3];
	property p_pwr;
		$rose(rst_n_i) |-> !status_o[1];
	endproperty
	a_pwr: assert property (p_pwr) else $error("latch set at reset");
	property p_cs;
		chip_erase_start_o |-> cs_n_i && $past(cs_n_i);
	endproperty
	a_cs: assert property (p_cs) else $error("erase in frame");
	property p_busy;
		chip_erase_start_o |-> ##[0:2] status_o[0];
	endproperty
	a_busy: assert property (p_busy) else $error("no busy");
	property p_done;
		core_done_i |-> ##[1:4] !status_o[1];
	endproperty
	a_done: assert property (p_done) else $error("latch kept");
	property p_otp;
		(func_o[7:4] & $past(func_o[7:4])) == $past(func_o[7:4]) && (!$past(func_o[1]) || func_o[1]);
	endproperty
	a_otp: assert property (p_otp) else $error("otp bit fell");
	property p_pwl;
		core_pause_o |-> ##[0:3] !status_o[1];
	endproperty
	a_pwl: assert property (p_pwl) else $error("latch after pause");
	property p_pfl;
		core_pause_o |-> ##[0:3] paused;
	endproperty
	a_pfl: assert property (p_pfl) else $error("no pause flag");
	property p_rfl;
		core_resume_o |-> ##[0:3] !paused;
	endproperty
	a_rfl: assert property (p_rfl) else $error("pause flag kept");
	property p_quiet;
		paused |-> !(prog_start_o || erase_start_o || chip_erase_start_o);
	endproperty
	a_quiet: assert property (p_quiet) else $error("start while paused");
	property p_mode;
		$changed(nibble_mode_o) |-> cs_n_i;
	endproperty
	a_mode: assert property (p_mode) else $error("mode in frame");
endmodule

// *** bench/flash_host.sv ***
// Host model: frames commands on the serial clock and chip select.
// Assumes mode 0 timing; the clock stands low outside frames.
`timescale 1ns/1ps
module flash_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic [3:0] io_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h5;
	end
	// Sends n bits MSB first, a nibble per clock in nibble mode.
	task automatic send(input logic [39:0] d, input int n, input bit nib);
		int w;
		w = nib ? 4 : 1;
		cs_n_o = 1'b0;
		#20;
		for (int i = n; i > 0; i -= w) begin
			io_o = nib ? d[i - 1 -: 4] : {~io_o[3:1], d[i - 1]};
			#7.5 sclk_o = 1'b1;
			#7.5 sclk_o = 1'b0;
		end
		#10 cs_n_o = 1'b1;
		io_o = ~io_o;
		#400;
	endtask
endmodule

// *** bench/tb_flash_write_erase_suspend_control.sv ***
// Self-checking bench for the write, erase and suspend controller.
// Assumes the host model and the checker file are compiled first.
`timescale 1ns/1ps
module tb_flash_write_erase_suspend_control;
	localparam int LAT = 20;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic core_done_i = 1'b0;
	logic sclk;
	logic cs_n;
	logic [3:0] io;
	logic [3:0] io_out;
	logic [3:0] io_oe;
	wire [5:0] pl;
	logic [7:0] rd_cap = 8'h00;
	logic nib_mode;
	logic [7:0] status;
	logic [7:0] func;
	int cnt[6];
	int fail_count = 0;
	int num_checks = 0;
	bit nib = 0;
	bit oe_seen = 0;
	flash_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(io));
	flash_write_erase_suspend_control #(.SUSP_LAT(LAT)) u_dut (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.io_i(io), .io_o(io_out), .io_oe_o(io_oe), .core_done_i(core_done_i),
		.prog_start_o(pl[0]), .erase_start_o(pl[1]), .chip_erase_start_o(pl[2]),
		.core_pause_o(pl[3]), .core_resume_o(pl[4]), .soft_reset_o(pl[5]),
		.nibble_mode_o(nib_mode), .status_o(status), .func_o(func));
	always #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		for (int k = 0; k < 6; k++) begin
			if (pl[k] === 1'b1) cnt[k] = cnt[k] + 1;
		end
	end
	always @(posedge sclk) begin
		if ((|io_oe) === 1'b1) oe_seen = 1;
		if (io_oe === 4'h2) rd_cap = {rd_cap[6:0], io_out[1]};
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic op(input logic [39:0] d, input int n);
		@(negedge mclk_i);
		u_host.send(d, n, nib);
	endtask
	task automatic ticks(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic done_pulse();
		@(negedge mclk_i);
		core_done_i = 1'b1;
		@(negedge mclk_i);
		core_done_i = 1'b0;
		ticks(4);
	endtask
	task automatic t_latch();
		chk(status, 8'h00, "st rst");
		op(40'h06, 8);
		chk(status & 8'h02, 8'h02, "write_permit_set_cmd");
		op(40'h04, 8);
		chk(status & 8'h02, 8'h00, "write_permit_clear_cmd");
	endtask
	task automatic t_chip();
		int c;
		c = cnt[2];
		op(40'hC7, 8);
		chk(8'(cnt[2] - c), 8'h00, "no latch");
		op(40'h06, 8);
		op(40'h30, 7);
		chk(8'(cnt[2] - c), 8'h00, "partial");
		op(40'h60, 8);
		chk(8'(cnt[2] - c), 8'h01, "chip");
		chk(status & 8'h01, 8'h01, "busy");
		oe_seen = 0;
		op(40'h0500, 16);
		chk({7'h00, oe_seen}, 8'h01, "status_read_cmd");
		chk(rd_cap, 8'h03, "status_read_cmd data");
		done_pulse();
		chk(status & 8'h03, 8'h00, "done");
	endtask
	task automatic t_nib();
		op(40'h35, 8);
		chk({7'h00, nib_mode}, 8'h01, "nib on");
		nib = 1;
		op(40'h06, 8);
		chk(status & 8'h02, 8'h02, "nib write_permit_set_cmd");
		op(40'h04, 8);
		op(40'hF5, 8);
		chk({7'h00, nib_mode}, 8'h00, "nib off");
		nib = 0;
	endtask
	task automatic t_susp(input int k);
		int p;
		int r;
		int s;
		logic [7:0] f;
		p = cnt[1 - k];
		r = cnt[4];
		s = cnt[3];
		f = k ? 8'h04 : 8'h08;
		if (k) begin
			op(40'h35, 8);
			nib = 1;
		end
		op(40'h06, 8);
		op(k ? 40'h020001005A : 40'hD7001000, k ? 40 : 32);
		chk(8'(cnt[1 - k] - p), 8'h01, "start");
		op(k ? 40'hB0 : 40'h75, 8);
		chk(8'(cnt[3] - s), 8'h01, "pause");
		chk(func & f, f, "flag");
		chk(status & 8'h03, 8'h01, "settle");
		op(40'h06, 8);
		chk(status & 8'h02, 8'h00, "settle write_permit_set_cmd");
		ticks(LAT);
		chk(status & 8'h01, 8'h00, "ready");
		op(40'h06, 8);
		chk(status & 8'h02, 8'h00, "paused write_permit_set_cmd");
		oe_seen = 0;
		op(40'h4800, 16);
		chk({7'h00, oe_seen}, 8'h01, "function_reg_read_cmd");
		if (!k) chk(rd_cap, f, "function_reg_read_cmd data");
		op(k ? 40'h30 : 40'h7A, 8);
		chk(8'(cnt[4] - r), 8'h01, "resume");
		chk(func & f, 8'h00, "unflag");
		chk(status & 8'h01, 8'h01, "rebusy");
		done_pulse();
		if (k) begin
			op(40'hF5, 8);
			nib = 0;
		end
	endtask
	task automatic t_rst();
		int r;
		r = cnt[5];
		op(40'h99, 8);
		chk(8'(cnt[5] - r), 8'h00, "bare rst");
		op(40'h66, 8);
		op(40'h99, 8);
		chk(8'(cnt[5] - r), 8'h01, "rst");
	endtask
	task automatic t_regs();
		op(40'h06, 8);
		op(40'h42F2, 16);
		ticks(70);
		chk(func, 8'hF2, "fr wr");
		op(40'h06, 8);
		op(40'h4200, 16);
		ticks(70);
		chk(func, 8'hF2, "otp");
		op(40'h06, 8);
		op(40'h01FC, 16);
		ticks(70);
		chk(status, 8'hFC, "st wr");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		ticks(12);
		rst_n_i = 1'b1;
		ticks(4);
		t_latch();
		t_chip();
		t_nib();
		t_susp(0);
		t_susp(1);
		t_rst();
		t_regs();
		test_done();
	end
	initial begin
		#500000;
		fail_count++;
		test_done();
	end
endmodule
bind flash_write_erase_suspend_control flash_ctl_checker u_chk (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .core_done_i(core_done_i),
	.prog_start_o(prog_start_o), .erase_start_o(erase_start_o),
	.chip_erase_start_o(chip_erase_start_o), .core_pause_o(core_pause_o),
	.core_resume_o(core_resume_o), .nibble_mode_o(nibble_mode_o),
	.status_o(status_o), .func_o(func_o));
